/* File: rtl/tic_map.vh */
// Register offsets, field positions and field codes of the capture channel
`ifndef TIC_MAP_VH
`define TIC_MAP_VH
`define TIC_CTRL_OFS      4'h0
`define TIC_IOCTL_OFS     4'h1
`define TIC_MODE_OFS      4'h2
`define TIC_IRQEN_OFS     4'h3
`define TIC_START_OFS     4'h4
`define TIC_COUNT_OFS     4'h5
`define TIC_CAPA_OFS      4'h6
`define TIC_STATUS_OFS    4'h7
`define TIC_PSC_LSB       0
`define TIC_EDGE_LSB      3
`define TIC_CLEAR_SOURCE_SELECT_LSB      5
`define TIC_IOA_LSB       0
`define TIC_MD_LSB        0
`define TIC_BFA_BIT       4
`define TIC_IEA_BIT       0
`define TIC_IEV_BIT       4
`define TIC_ST_CAP_BIT    0
`define TIC_ST_OVF_BIT    1
`define TIC_CLEAR_SOURCE_SELECT_CAPA     3'h1
`define TIC_IOA_BOTH      4'hA
`define TIC_MD_NORMAL     4'h0
`define TIC_PSC_DIV1      3'h0
`define TIC_EDGE_RISE     2'h0
`define TIC_CNT_MAX       16'hFFFF
`endif

/* File: rtl/tic_channel.v */
// One 16-bit timer channel with both-edge input capture, Avalon-MM slave
//
// How it works
// RULE_01: clear-source 001b clears counter on capture or compare match of register A.
// RULE_02: io control 1010b makes register A capture on both pin edges.
// RULE_03: in capture setup register A holds latched counter, not a threshold.
// RULE_04: mode 0 is normal mode; buffer-A enable 0 means no buffering.
// RULE_05: capture interrupt forwarded only while capture irq enable is 1.
// RULE_06: overflow interrupt forwarded only while overflow irq enable is 1.
// RULE_07: counter advances only while count start bit is 1.
// RULE_08: counter holds its value while count start bit is 0.
// RULE_09: overflow interrupt raised when counter wraps past FFFFh.
// RULE_10: capture at FFFFh latches and interrupts but raises no overflow.
// RULE_11: prescale 000b counts undivided clock; edge 00b counts rising edges.
`timescale 1ns/1ps
`include "tic_map.vh"
module tic_channel
(
   input  wire        clk,
   input  wire        rst,
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   input  wire        capture_input_pin,
   output reg         capture_a_interrupt,
   output reg         overflow_interrupt
);
   reg  [7:0]  counter_control_reg;
   reg  [7:0]  io_control_high_reg;
   reg  [7:0]  channel_mode_reg;
   reg  [7:0]  irq_enable_reg;
   reg         count_start_bit;
   reg  [15:0] counter_value;
   reg  [15:0] capture_compare_a;
   reg         cap_flag;
   reg         ovf_flag;
   reg  [2:0]  pin_sync;
   reg         pin_level;
   reg         done;

   wire [2:0] clock_prescale_select =
      counter_control_reg[`TIC_PSC_LSB +: 3];
   wire [1:0] clock_edge_select = counter_control_reg[`TIC_EDGE_LSB +: 2];
   wire [2:0] clear_source_select = counter_control_reg[`TIC_CLEAR_SOURCE_SELECT_LSB +: 3];
   wire [3:0] io_control_a = io_control_high_reg[`TIC_IOA_LSB +: 4];
   wire [3:0] operating_mode_field = channel_mode_reg[`TIC_MD_LSB +: 4];
   wire       buffer_a_enable = channel_mode_reg[`TIC_BFA_BIT];
   wire       capture_a_irq_enable = irq_enable_reg[`TIC_IEA_BIT];
   wire       overflow_irq_enable = irq_enable_reg[`TIC_IEV_BIT];

   // Only the documented prescale, edge, mode and buffer codes run; other codes there leave the timer idle
   wire cfg_ok = (clock_prescale_select == `TIC_PSC_DIV1) &&
                 (clock_edge_select == `TIC_EDGE_RISE) &&              // RULE_11
                 (operating_mode_field == `TIC_MD_NORMAL) &&
                 !buffer_a_enable;                                     // RULE_04
   wire cap_mode = (io_control_a == `TIC_IOA_BOTH);                     // RULE_02
   // Stages 2 and 3 agree on a level other than the last accepted one
   wire pin_agree = (pin_sync[2] == pin_sync[1]);
   wire cap_edge = cap_mode && pin_agree &&
                   (pin_sync[2] != pin_level);                         // RULE_02
   wire cmp_match = !cap_mode && (counter_value == capture_compare_a);
   wire clr_a = (clear_source_select == `TIC_CLEAR_SOURCE_SELECT_CAPA) &&
                (cap_edge || cmp_match);                               // RULE_01
   wire run = count_start_bit && cfg_ok;                               // RULE_07
   wire wrap = run && (counter_value == `TIC_CNT_MAX) && !cap_edge;     // RULE_10
   // Request seen in its first cycle, while waitrequest still stands
   wire acc = (avs_read || avs_write) && avs_waitrequest;
   // Write lands at the edge where the master sees waitrequest low
   wire wr = avs_write && !avs_waitrequest;
   wire wr_lo = wr && avs_byteenable[0];
   // Address decode
   wire sel_ctrl = (avs_address == `TIC_CTRL_OFS);
   wire sel_ioctl = (avs_address == `TIC_IOCTL_OFS);
   wire sel_mode = (avs_address == `TIC_MODE_OFS);
   wire sel_irqen = (avs_address == `TIC_IRQEN_OFS);
   wire sel_start = (avs_address == `TIC_START_OFS);
   wire sel_count = (avs_address == `TIC_COUNT_OFS);
   wire sel_capa = (avs_address == `TIC_CAPA_OFS);
   wire sel_status = (avs_address == `TIC_STATUS_OFS);
   // Flag set and clear terms
   wire cap_set = run && (cap_edge || cmp_match);
   wire cap_clr = wr && sel_status && avs_writedata[`TIC_ST_CAP_BIT];
   wire ovf_clr = wr && sel_status && avs_writedata[`TIC_ST_OVF_BIT];
   // Waitrequest drops for one cycle, one cycle after a new request
   wire next_waitrequest = !((avs_read || avs_write) && !done &&
                             avs_waitrequest);

   // Three-stage pin synchroniser; edge accepted when stages 2 and 3 agree
   always @(posedge clk)
   begin
      if (rst)
      begin
         pin_sync <= 3'h0;
         pin_level <= 1'b0;
      end
      else
      begin
         pin_sync <= {pin_sync[1:0], capture_input_pin};
         if (pin_sync[2] == pin_sync[1])
            pin_level <= pin_sync[2];
      end
   end

   // Counter, capture register and flags
   always @(posedge clk)
   begin
      if (rst)
      begin
         counter_value <= 16'h0000;
         capture_compare_a <= 16'h0000;
         cap_flag <= 1'b0;
         ovf_flag <= 1'b0;
      end
      else
      begin
         // Software write of the counter wins over counting
         if (wr_lo && sel_count)
            counter_value <= avs_writedata[15:0];
         else if (run && clr_a)                                        // RULE_01
            counter_value <= 16'h0000;
         else if (run)                                                 // RULE_07
            counter_value <= counter_value + 16'h0001;                  // RULE_09
         else
            counter_value <= counter_value;                            // RULE_08
         // Capture takes the count before it clears
         if (run && cap_edge)
            capture_compare_a <= counter_value;                        // RULE_03
         else if (wr_lo && sel_capa)
            capture_compare_a <= avs_writedata[15:0];
         // Hardware set wins over software clear
         if (cap_set)
            cap_flag <= 1'b1;
         else if (cap_clr)
            cap_flag <= 1'b0;
         if (wrap)                                                     // RULE_09
            ovf_flag <= 1'b1;
         else if (ovf_clr)
            ovf_flag <= 1'b0;
      end
   end

   // Interrupt requests gated by enables
   // Registered so the requests leave straight from flops
   always @(posedge clk)
   begin
      if (rst)
      begin
         capture_a_interrupt <= 1'b0;
         overflow_interrupt <= 1'b0;
      end
      else
      begin
         capture_a_interrupt <= cap_flag && capture_a_irq_enable;     // RULE_05
         overflow_interrupt <= ovf_flag && overflow_irq_enable;       // RULE_06
      end
   end

   // Avalon slave: one wait cycle, answer on second cycle of request
   always @(posedge clk)
   begin
      if (rst)
      begin
         counter_control_reg <= 8'h00;
         io_control_high_reg <= 8'h00;
         channel_mode_reg <= 8'h00;
         irq_enable_reg <= 8'h00;
         count_start_bit <= 1'b0;
         avs_readdata <= 32'h00000000;
         avs_waitrequest <= 1'b1;
         done <= 1'b0;
      end
      else
      begin
         done <= acc && !done;
         avs_waitrequest <= next_waitrequest;
         // Register writes with byte lane 0 off are ignored; status flag clears do not check byte lane 0
         if (wr_lo)
         begin
            if (sel_ctrl)
               counter_control_reg <= avs_writedata[7:0];
            else if (sel_ioctl)
               io_control_high_reg <= avs_writedata[7:0];
            else if (sel_mode)
               channel_mode_reg <= avs_writedata[7:0];
            else if (sel_irqen)
               irq_enable_reg <= avs_writedata[7:0];
            else if (sel_start)
               count_start_bit <= avs_writedata[0];
         end
         // Read data registered in the first cycle, held to the answer
         if (avs_read && avs_waitrequest)
         begin
            if (sel_ctrl)
               avs_readdata <= {24'h000000, counter_control_reg};
            else if (sel_ioctl)
               avs_readdata <= {24'h000000, io_control_high_reg};
            else if (sel_mode)
               avs_readdata <= {24'h000000, channel_mode_reg};
            else if (sel_irqen)
               avs_readdata <= {24'h000000, irq_enable_reg};
            else if (sel_start)
               avs_readdata <= {31'h00000000, count_start_bit};
            else if (sel_count)
               avs_readdata <= {16'h0000, counter_value};
            else if (sel_capa)
               avs_readdata <= {16'h0000, capture_compare_a};
            else if (sel_status)
               avs_readdata <= {29'h00000000, pin_level, ovf_flag, cap_flag};
            // Unmapped addresses read as zero
            else
               avs_readdata <= 32'h00000000;
         end
      end
   end
endmodule // tic_channel

/* File: dv/tic_channel_sva.sv */
// Port-level assertions for the capture channel
`timescale 1ns/1ps
module tic_channel_sva
(
   input wire        clk,
   input wire        rst,
   input wire [3:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0]  avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   input wire        capture_a_interrupt,
   input wire        overflow_interrupt
);
   wire req = avs_read | avs_write;
   reg  iea;
   reg  iev;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Shadow of the interrupt enables
   always @(posedge clk)
   begin
      if (rst) {iea, iev} <= 2'h0;
      else if (avs_write && !avs_waitrequest && avs_address == 4'h3
               && avs_byteenable[0])
         {iea, iev} <= {avs_writedata[0], avs_writedata[4]};
   end
   a_wait_answer: assert property (req && avs_waitrequest |=>
      !avs_waitrequest) else $error("no bus answer");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_idle_wait: assert property (!req |=> avs_waitrequest)
      else $error("answer without request");
   a_cap_gate: assert property (capture_a_interrupt |-> $past(iea))
      else $error("capture interrupt while disabled");
   a_ovf_gate: assert property (overflow_interrupt |-> $past(iev))
      else $error("overflow interrupt while disabled");
   a_rd_hold: assert property (!(avs_read && avs_waitrequest) |=>
      $stable(avs_readdata)) else $error("read data moved");
   a_unmapped_zero: assert property (avs_read && avs_waitrequest &&
      avs_address[3] |=> avs_readdata == 32'h0) else $error("unmapped read");
   a_reset_state: assert property ($fell(rst) |-> avs_waitrequest &&
      !capture_a_interrupt && !overflow_interrupt) else $error("reset state");
endmodule // tic_channel_sva
bind tic_channel tic_channel_sva tic_channel_sva_i (.clk(clk), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .capture_a_interrupt(capture_a_interrupt),
   .overflow_interrupt(overflow_interrupt));

/* File: dv/tic_pulse_src.sv */
// External pulse source: one high pulse of a given length per fire
`timescale 1ns/1ps
module tic_pulse_src
(
   input wire       clk,
   input wire       fire,
   input wire [7:0] high_len,
   output reg       pin
);
   reg [7:0] left = 8'h0;
   initial pin = 1'b0;
   always @(posedge clk)
   begin
      if (fire) {pin, left} <= {1'b1, high_len};
      else if (left > 8'h1) left <= left - 8'h1;
      else if (left == 8'h1) {pin, left} <= 9'h0;
   end
endmodule // tic_pulse_src

/* File: dv/testbench.sv */
// Self-checking bench for the capture channel
`timescale 1ns/1ps
module testbench;
   reg clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, fire = 1'b0;
   reg [3:0]  avs_address = 4'h0;
   reg [31:0] avs_writedata = 32'h0, r;
   reg [7:0]  hl = 8'h0;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, pin, capture_a_interrupt, overflow_interrupt;
   integer num_errors = 0, checks_done = 0, cyc = 0, seed = 32'h146f;
   reg [31:0] q[$];
   tic_channel tic_channel_i (.clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .capture_input_pin(pin),
      .capture_a_interrupt(capture_a_interrupt),
      .overflow_interrupt(overflow_interrupt));
   tic_pulse_src tic_pulse_src_i (.clk(clk), .fire(fire), .high_len(hl),
      .pin(pin));
   always #2 clk = ~clk;
   task complete_run;
   begin
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   end
   endtask
   task check(input [31:0] seen, input [31:0] exp);
   begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
         num_errors = num_errors + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task bus(input rd, input [3:0] a, input [31:0] d);
   begin
      @(posedge clk);
      {avs_read, avs_write, avs_address, avs_writedata} <= {rd, !rd, a, d};
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      {avs_read, avs_write} <= 2'h0;
   end
   endtask
   task rd(input [3:0] a, input [31:0] exp);
   begin
      q.push_back(exp);
      bus(1'b1, a, 32'h0);
   end
   endtask
   task pulse(input [7:0] len);
   begin
      @(posedge clk);
      {fire, hl} <= {1'b1, len};
      @(posedge clk);
      fire <= 1'b0;
      repeat (len + 12) @(posedge clk);
   end
   endtask
   // Read results are compared in order of issue
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (avs_read && avs_waitrequest === 1'b0) check(avs_readdata, q.pop_front());
      if (cyc == 4000) begin num_errors = num_errors + 1; complete_run; end
   end
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 4'h0, 32'h20);
      bus(1'b0, 4'h1, 32'hA);
      bus(1'b0, 4'h2, 32'h0);
      bus(1'b0, 4'h3, 32'h11);
      rd(4'h0, 32'h20);
      r = $random(seed) & 32'h7FFF;
      bus(1'b0, 4'h5, r);
      repeat (8) @(posedge clk);
      rd(4'h5, r);
      bus(1'b0, 4'h4, 32'h1);
      r = 8 + ($random(seed) & 15);
      pulse(r[7:0]);
      rd(4'h6, r - 1);
      rd(4'h7, 32'h1);
      check(capture_a_interrupt, 32'h1);
      bus(1'b0, 4'h7, 32'h3);
      bus(1'b0, 4'h3, 32'h0);
      pulse(8'd20);
      rd(4'h6, 32'd19);
      check(capture_a_interrupt, 32'h0);
      bus(1'b0, 4'h7, 32'h3);
      bus(1'b0, 4'h5, 32'hFFF0);
      repeat (30) @(posedge clk);
      rd(4'h7, 32'h2);
      check(overflow_interrupt, 32'h0);
      bus(1'b0, 4'h3, 32'h10);
      repeat (3) @(posedge clk);
      check(overflow_interrupt, 32'h1);
      rd(4'hC, 32'h0);
      complete_run;
   end
endmodule // testbench
